// *** rtl/ddrwr_pkg.sv ***
/*
 Constants shared by the warm-reset self-refresh sequencer: register offsets,
 field positions, reset values and timing counts.
 Assumes a 50 MHz ref_clk and a plain strobe register port.
*/
package ddrwr_pkg;
	localparam int ClkPeriodNs = 20;
	localparam int AddrW = 4;
	localparam logic [AddrW-1:0] OffRefresh = 4'h0; // Refresh interval
	localparam logic [AddrW-1:0] OffControl = 4'h4; // Core misc control 0
	localparam logic [AddrW-1:0] OffStatus = 4'h8; // Sequencer status
	localparam int ExtendBit = 6;
	localparam int HoldBit = 5;
	localparam logic [15:0] RefreshReset = 16'h0186;
	localparam logic [7:0] ControlReset = 8'h00;
	localparam int HoldTimeNs = 2000; // Fixed warm reset hold time
	localparam int HoldCycles = (HoldTimeNs + ClkPeriodNs - 1) / ClkPeriodNs;
	localparam int CntW = 16;
	typedef enum logic [4:0] {
		StIdle = 5'b0_0001,
		StEnterSr = 5'b0_0010,
		StSelfRef = 5'b0_0100,
		StExitSr = 5'b0_1000,
		StActive = 5'b1_0000
	} ddrwr_state_e;
endpackage

// *** rtl/ddrwr_seq.sv ***
/*
 Warm-reset self-refresh sequencer of the external memory controller.
 Assumes warmResetReq arrives from another domain and that the memory side
 acts on one-cycle command pulses. Register port: read data one cycle late.
*/
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module ddrwr_seq #(
	parameter int HoldCyc = ddrwr_pkg::HoldCycles
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic warmResetReq,
	input wire logic [ddrwr_pkg::AddrW-1:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [31:0] regRdata,
	output logic srEnterCmd,
	output logic srExitCmd,
	output logic refreshCmd,
	output logic clkBypassSel,
	output logic trafficEnable
);
	import ddrwr_pkg::*;

	logic syncA_q, syncB_q;
	ddrwr_state_e state_q, state_d;
	logic [15:0] refresh_q, refresh_d;
	logic [7:0] control_q, control_d;
	logic [CntW-1:0] holdCnt_q, holdCnt_d;
	logic [15:0] refCnt_q, refCnt_d;
	logic [31:0] rdata_d;
	logic enter_d, exit_d, refCmd_d, bypass_d, traffic_d;
	logic bypass_q;

	function automatic logic isWrite(input logic [AddrW-1:0] a, input logic [AddrW-1:0] off, input logic w);
		return w && (a == off);
	endfunction

	// Two-flop synchroniser; only the second flop feeds logic
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			syncA_q <= 1'b0;
			syncB_q <= 1'b0;
		end else begin
			syncA_q <= warmResetReq;
			syncB_q <= syncA_q;
		end
	end

	// Next-state logic for registers, sequencer and refresh timer
	always_comb begin
		state_d = state_q;
		refresh_d = refresh_q;
		control_d = control_q;
		holdCnt_d = holdCnt_q;
		refCnt_d = refCnt_q;
		enter_d = 1'b0;
		exit_d = 1'b0;
		refCmd_d = 1'b0;
		bypass_d = bypass_q;
		traffic_d = 1'b0;
		rdata_d = 32'h0000_0000;
		if (isWrite(regAddr, OffRefresh, regWrite))
			refresh_d = regWdata[15:0];
		if (isWrite(regAddr, OffControl, regWrite))
			control_d = regWdata[7:0];
		if (regRead) begin
			case (regAddr)
				OffRefresh: rdata_d = {16'h0000, refresh_q};
				OffControl: rdata_d = {24'h00_0000, control_q};
				OffStatus: rdata_d = {26'h000_0000, bypass_q, state_q};
				default: rdata_d = 32'h0000_0000;
			endcase
		end
		case (state_q)
			StIdle: begin
				state_d = StActive;
			end
			StActive: begin
				traffic_d = 1'b1;
				if (refCnt_q >= refresh_q) begin
					refCnt_d = 16'h0000;
					refCmd_d = 1'b1;
				end else begin
					refCnt_d = refCnt_q + 16'h0001;
				end
				if (syncB_q) begin
					traffic_d = 1'b0;
					state_d = StEnterSr;
				end
			end
			StEnterSr: begin
				enter_d = 1'b1;
				holdCnt_d = '0;
				state_d = StSelfRef;
			end
			StSelfRef: begin
				bypass_d = syncB_q;
				if (holdCnt_q < CntW'(HoldCyc))
					holdCnt_d = holdCnt_q + 1'b1;
				if (control_q[ExtendBit]) begin
					// Stay parked while hold bit is set, giving software time to relock the PLL
					if (!control_q[HoldBit] && !syncB_q) begin
						bypass_d = 1'b0;
						state_d = StExitSr;
					end
				end else if (!syncB_q && holdCnt_q >= CntW'(HoldCyc)) begin
					state_d = StExitSr;
				end
			end
			StExitSr: begin
				exit_d = 1'b1;
				bypass_d = 1'b0;
				refCnt_d = 16'h0000;
				state_d = StActive;
			end
			default: state_d = StIdle;
		endcase
	end

	// Register stage
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= StIdle;
			refresh_q <= RefreshReset;
			control_q <= ControlReset;
			holdCnt_q <= '0;
			refCnt_q <= 16'h0000;
			regRdata <= 32'h0000_0000;
			srEnterCmd <= 1'b0;
			srExitCmd <= 1'b0;
			refreshCmd <= 1'b0;
			bypass_q <= 1'b0;
			trafficEnable <= 1'b0;
		end else begin
			state_q <= state_d;
			refresh_q <= refresh_d;
			control_q <= control_d;
			holdCnt_q <= holdCnt_d;
			refCnt_q <= refCnt_d;
			regRdata <= rdata_d;
			srEnterCmd <= enter_d;
			srExitCmd <= exit_d;
			refreshCmd <= refCmd_d;
			bypass_q <= bypass_d;
			trafficEnable <= traffic_d;
		end
	end
	assign clkBypassSel = bypass_q;

	// Bypass select may only move while parked in self-refresh
	AST_CLK_STABLE: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(state_q == StActive) |-> $stable(bypass_q)) else $error("clock select moved while active");
	AST_ENTER: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(state_q == StActive && syncB_q) |=> ##1 srEnterCmd) else $error("no self-refresh entry");
	sequence seqHoldDone;
		(state_q == StSelfRef && !control_q[ExtendBit] && !syncB_q && holdCnt_q >= CntW'(HoldCyc));
	endsequence
	AST_EXIT_TIME: assert property (@(posedge ref_clk) disable iff (!rst_n)
		seqHoldDone |=> ##1 srExitCmd) else $error("no exit after hold time");
	AST_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(state_q == StSelfRef && control_q[ExtendBit] && control_q[HoldBit]) |=> !srExitCmd)
		else $error("left self-refresh while held");
	AST_BYPASS: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(state_q == StSelfRef && syncB_q) |=> bypass_q) else $error("bypass not selected");
	AST_EXIT_CLK: assert property (@(posedge ref_clk) disable iff (!rst_n)
		srExitCmd |-> !bypass_q) else $error("exit on bypass clock");
	AST_TRAFFIC: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$rose(srExitCmd) && !syncB_q |=> trafficEnable) else $error("traffic not resumed");
	AST_REFRESH: assert property (@(posedge ref_clk) disable iff (!rst_n)
		refreshCmd |-> $past(state_q) == StActive) else $error("refresh outside active");

	// Parked memory must see neither traffic nor refresh commands from us
	AST_SR_QUIET: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(state_q == StSelfRef) |-> !trafficEnable) else $error("traffic while parked");
	AST_SR_NO_REFRESH: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(state_q == StSelfRef) |-> !refreshCmd) else $error("refresh while parked");

	// Entry and exit command outputs are single-cycle pulses; a stuck pulse would repeat the command
	AST_ENTER_PULSE: assert property (@(posedge ref_clk) disable iff (!rst_n)
		srEnterCmd |=> !srEnterCmd) else $error("entry pulse too long");
	AST_EXIT_PULSE: assert property (@(posedge ref_clk) disable iff (!rst_n)
		srExitCmd |=> !srExitCmd) else $error("exit pulse too long");

	// Entry step followed by the parked step, used to check the entry command order
	sequence seqEnterStep;
		(state_q == StEnterSr);
	endsequence
	sequence seqParkedStep;
		(state_q == StSelfRef && srEnterCmd);
	endsequence
	AST_ENTER_ORDER: assert property (@(posedge ref_clk) disable iff (!rst_n)
		seqEnterStep |=> seqParkedStep) else $error("entry command out of order");

	// Bypass select never rises before the memory has been told to park
	AST_BYPASS_LATE: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$rose(bypass_q) |-> (state_q == StSelfRef) && !srEnterCmd) else $error("bypass before parking");

	// Read data only stands in the cycle after a read strobe
	AST_RDATA_IDLE: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!$past(regRead) |-> (regRdata == 32'h0000_0000)) else $error("read data without read");

	// Held extension must never time out on its own
	AST_HOLD_NO_TIMEOUT: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(state_q == StSelfRef && control_q[ExtendBit] && control_q[HoldBit]) |=> (state_q == StSelfRef))
		else $error("hold released by timer");
endmodule // ddrwr_seq

// *** testbench/ddrwr_sdram_model.sv ***
/* SDRAM side model: tracks self-refresh and counts illegal activity.
 Assumes one-cycle command pulses on ref_clk. */
`timescale 1ns/1ps
module ddrwr_sdram_model (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic srEnterCmd,
	input wire logic srExitCmd,
	input wire logic refreshCmd,
	input wire logic clkBypassSel,
	output logic inSr,
	output int errCnt
);
	// The memory reset pin is not modelled: contents are taken as kept across warm reset
	// A clock move while active would break the memory, so it is counted
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			inSr <= 1'b0;
			errCnt <= 0;
		end else begin
			if (srEnterCmd) inSr <= 1'b1;
			if (srExitCmd) inSr <= 1'b0;
			if ((refreshCmd && inSr) || ($changed(clkBypassSel) && !inSr && !srEnterCmd && !srExitCmd)) errCnt <= errCnt + 1;
		end
	end
endmodule // ddrwr_sdram_model

// *** testbench/tb_top.sv ***
/* Directed bench for the warm-reset sequencer.
 Assumes HoldCyc shortened to 4 and a 50 MHz ref_clk. */
`timescale 1ns/1ps
module tb_top;
	import ddrwr_pkg::*;
	logic ref_clk = 0, rst_n = 0, warmResetReq = 0, regWrite = 0, regRead = 0;
	logic [AddrW-1:0] regAddr = '0;
	logic [31:0] regWdata = '0, regRdata;
	logic srEnterCmd, srExitCmd, refreshCmd, clkBypassSel, trafficEnable, inSr;
	int failures = 0, n_compared = 0, errCnt, n;
	always #10 ref_clk = ~ref_clk;
	ddrwr_seq #(.HoldCyc(4)) i_ddrwr_seq (.ref_clk(ref_clk), .rst_n(rst_n), .warmResetReq(warmResetReq),
		.regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
		.srEnterCmd(srEnterCmd), .srExitCmd(srExitCmd), .refreshCmd(refreshCmd), .clkBypassSel(clkBypassSel),
		.trafficEnable(trafficEnable));
	ddrwr_sdram_model i_ddrwr_sdram_model (.ref_clk(ref_clk), .rst_n(rst_n), .srEnterCmd(srEnterCmd),
		.srExitCmd(srExitCmd), .refreshCmd(refreshCmd), .clkBypassSel(clkBypassSel), .inSr(inSr), .errCnt(errCnt));
	task automatic report_and_stop;
		if (failures == 0 && n_compared > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_compared++;
		if (s !== e) begin
			failures++;
			$display("BAD %s exp %h got %h", nm, e, s);
		end
	endtask
	// One-cycle strobes, changed just after the edge
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge ref_clk);
		regWrite <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e, input string nm);
		@(posedge ref_clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge ref_clk);
		regRead <= 1'b0;
		#1 chk(nm, e, regRdata);
	endtask
	// Bounded wait for a command pulse: 0 enter, 1 exit, 2 refresh
	task automatic waitFor(input int w, input int lim);
		n = 0;
		do begin
			@(posedge ref_clk);
			#1 n++;
			if (n > lim) begin
				chk("timeout", 0, 1);
				report_and_stop();
			end
		end while (((w == 0) ? srEnterCmd : (w == 1) ? srExitCmd : refreshCmd) !== 1'b1);
	endtask
	task automatic warm(input logic v);
		@(posedge ref_clk);
		warmResetReq <= v;
	endtask
	initial begin
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		// Short interval first, before the running count passes it
		wr(OffRefresh, 32'h0000_0005);
		waitFor(2, 400);
		waitFor(2, 10);
		chk("refresh period", 6, n);
		rd(OffControl, 32'h0000_0000, "control");
		rd(4'hC, 32'h0000_0000, "unmapped");
		rd(OffRefresh, 32'h0000_0005, "refresh");
		rd(OffStatus, 32'h0000_0010, "status active");
		warm(1'b1);
		waitFor(0, 10);
		chk("traffic in sr", 0, trafficEnable);
		@(posedge ref_clk);
		#1 chk("bypass", 1, clkBypassSel);
		warm(1'b0);
		waitFor(1, 30);
		chk("bypass at exit", 0, clkBypassSel);
		repeat (3) @(posedge ref_clk);
		#1 chk("traffic after", 1, trafficEnable);
		wr(OffControl, 32'h0000_0060);
		rd(OffControl, 32'h0000_0060, "control set");
		warm(1'b1);
		waitFor(0, 10);
		warm(1'b0);
		repeat (40) @(posedge ref_clk);
		#1 chk("held in sr", 1, inSr);
		rd(OffStatus, 32'h0000_0004, "status held");
		// Clock already restored by the sequencer when the request dropped, before the hold is cleared
		wr(OffControl, 32'h0000_0040);
		waitFor(1, 30);
		waitFor(2, 40);
		chk("model errors", 0, errCnt);
		report_and_stop();
	end
endmodule // tb_top
